// ---- design/cid_params.svh ----
// Constants for the instruction decoder: opcodes, forms, lengths and cycle counts.
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH
// ============================================================
// Timing and instruction lengths.
`define CID_MC_CLKS 4'hc
`define CID_MC_LAST (`CID_MC_CLKS - 4'h1)
`define CID_LEN1 2'h1
`define CID_LEN2 2'h2
`define CID_LEN3 2'h3
`define CID_CYC1 3'h1
`define CID_CYC2 3'h2
`define CID_CYC4 3'h4
// ============================================================
// Opcode columns and rows.
`define CID_HI_INC 4'h0
`define CID_HI_DEC 4'h1
`define CID_HI_ADD 4'h2
`define CID_HI_ADD_WITH_CARRY 4'h3
`define CID_HI_SUBTRACT_WITH_BORROW 4'h9
`define CID_HI_COMPARE_BRANCH_UNEQUAL 4'hb
`define CID_HI_DECREMENT_BRANCH_NONZERO 4'hd
`define CID_LO_ACC 4'h4
`define CID_LO_DIR 4'h5
`define CID_LO_IND 3'h3
`define CID_LO_PAGE 4'h1
// ============================================================
// Full opcodes.
`define CID_OP_NOP 8'h00
`define CID_OP_INC_DP 8'ha3
`define CID_OP_MUL 8'ha4
`define CID_OP_DIV 8'h84
`define CID_OP_DA 8'hd4
`define CID_OP_LAND 8'h53
`define CID_OP_LOR 8'h43
`define CID_OP_LXOR 8'h63
`define CID_OP_CLR_A 8'he4
`define CID_OP_CPL_A 8'hf4
`define CID_OP_RL 8'h23
`define CID_OP_RLC 8'h33
`define CID_OP_RR 8'h03
`define CID_OP_RRC 8'h13
`define CID_OP_SWAP 8'hc4
`define CID_OP_CT_DP 8'h93
`define CID_OP_CT_PC 8'h83
`define CID_OP_AUX_RD 8'he0
`define CID_OP_AUX_WR 8'hf0
`define CID_OP_XCHD0 8'hd6
`define CID_OP_XCHD1 8'hd7
`define CID_OP_CLR_C 8'hc3
`define CID_OP_SET_C 8'hd3
`define CID_OP_CPL_C 8'hb3
`define CID_OP_CLR_BIT 8'hc2
`define CID_OP_SET_BIT 8'hd2
`define CID_OP_CPL_BIT 8'hb2
`define CID_OP_JBC 8'h10
`define CID_OP_FCALL 8'h12
`define CID_OP_FJMP 8'h02
`define CID_OP_RET 8'h22
`define CID_OP_INTERRUPT_RETURN 8'h32
// ============================================================
// Addresses and fields.
`define CID_PSW_BYTE 8'hd0
`define CID_PSW_BLO 8'hd1
`define CID_PSW_BHI 8'hd7
`define CID_SFR_BIT 3'h7
`define CID_REG_FLD 2:0
`define CID_IND_BIT 0
`define CID_PAGE_OP 7:5
`define CID_PAGE_PC 15:11
`define CID_PAGE_LOW 4
`endif

// ---- design/cid_pkg.sv ----
// Types shared by the instruction decoder modules.
package cid_pkg;
	// ============================================================
	// Operation classes.
	typedef enum logic [5:0] {
		CID_NOP = 6'b000000, CID_ADD = 6'b000001, CID_ADD_WITH_CARRY = 6'b000010,
		CID_SUBTRACT_WITH_BORROW = 6'b000011, CID_INC = 6'b000100, CID_DEC = 6'b000101,
		CID_INC_DP = 6'b000110, CID_MUL = 6'b000111, CID_DIV = 6'b001000,
		CID_DA = 6'b001001, CID_LAND = 6'b001010, CID_LOR = 6'b001011,
		CID_LXOR = 6'b001100, CID_CLR_A = 6'b001101, CID_CPL_A = 6'b001110,
		CID_RL = 6'b001111, CID_RLC = 6'b010000, CID_RR = 6'b010001,
		CID_RRC = 6'b010010, CID_SWAP = 6'b010011, CID_CT_DP = 6'b010100,
		CID_CT_PC = 6'b010101, CID_AUX_RD = 6'b010110, CID_AUX_WR = 6'b010111,
		CID_LOW_NIBBLE_EXCHANGE = 6'b011000, CID_CLR_C = 6'b011001, CID_SET_C = 6'b011010,
		CID_CPL_C = 6'b011011, CID_CLR_BIT = 6'b011100, CID_SET_BIT = 6'b011101,
		CID_CPL_BIT = 6'b011110, CID_JBC = 6'b011111, CID_PCALL = 6'b100000,
		CID_PJMP = 6'b100001, CID_FCALL = 6'b100010, CID_FJMP = 6'b100011,
		CID_COMPARE_BRANCH_UNEQUAL = 6'b100100, CID_DECREMENT_BRANCH_NONZERO = 6'b100101, CID_RET = 6'b100110,
		CID_INTERRUPT_RETURN = 6'b100111, CID_OTHER = 6'b111111
	} cid_op_t;
	// ============================================================
	// Operand addressing modes.
	typedef enum logic [2:0] {
		CID_AM_NONE = 3'b000, CID_AM_REG = 3'b001, CID_AM_DIR = 3'b010,
		CID_AM_IND = 3'b011, CID_AM_IMM = 3'b100, CID_AM_BIT = 3'b101
	} cid_am_t;
	typedef enum logic [1:0] {
		CID_ST_IDLE = 2'b00, CID_ST_OPND = 2'b01, CID_ST_EXEC = 2'b10
	} cid_st_t;
	typedef struct packed {
		cid_op_t cls;
		cid_am_t mode;
		logic [1:0] len;
		logic [2:0] cyc;
		logic fc;
		logic fov;
		logic fac;
		logic cclr;
	} cid_dec_t;
	typedef struct packed {
		cid_st_t fsm;
		logic [7:0] op;
		cid_dec_t dec;
		logic [15:0] pc;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [1:0] left;
		logic [2:0] mcl;
		logic rdy;
		logic busy;
		logic done;
		logic tick;
		logic [2:0] rsel;
		logic isel;
		logic [7:0] dir;
		logic sfr;
		logic program_status_word;
		logic [7:0] imm;
		logic [15:0] tgt;
		logic take;
		logic bclr;
	} cid_state_t;
	typedef struct packed {
		logic [3:0] cnt;
	} cid_mc_t;
endpackage : cid_pkg

// ---- design/cid_mcycle.sv ----
// Machine cycle timer: one tick every twelve clocks while running.
`timescale 1ns/100ps
`include "cid_params.svh"
module cid_mcycle
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	output logic tick
);
	import cid_pkg::*;

	cid_mc_t s_reg;
	cid_mc_t s_next;

	// ============================================================
	// Phase counter.
	always_comb
	begin
		s_next = s_reg;
		if (!run)
			s_next.cnt = 4'h0;
		else if (s_reg.cnt == `CID_MC_LAST)
			s_next.cnt = 4'h0;
		else
			s_next.cnt = s_reg.cnt + 4'h1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// Restarting from zero whenever idle keeps every instruction aligned to its own start.
	assign tick = run && (s_reg.cnt == `CID_MC_LAST);

endmodule : cid_mcycle

// ---- design/cid_decoder.sv ----
// Instruction decoder and execution sequencer for the 8-bit core.
// ============================================================
`timescale 1ns/100ps
`include "cid_params.svh"
module cid_decoder
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic code_valid,
	input wire logic [7:0] code_byte,
	input wire logic [15:0] pc_in,
	input wire logic bit_val,
	output logic code_ready,
	output logic busy,
	output logic instr_done,
	output logic mc_tick,
	output cid_pkg::cid_op_t op_class,
	output cid_pkg::cid_am_t addr_mode,
	output logic [1:0] instr_len,
	output logic [2:0] exec_cycles,
	output logic carry_upd,
	output logic overflow_flag_upd,
	output logic aux_carry_flag_upd,
	output logic carry_clr,
	output logic [2:0] reg_sel,
	output logic ind_sel,
	output logic [7:0] dir_addr,
	output logic dir_is_sfr,
	output logic status_word_touch,
	output logic [7:0] imm_data,
	output logic [15:0] branch_target,
	output logic branch_take,
	output logic bit_clear
);
	import cid_pkg::*;

	cid_state_t s_reg;
	cid_state_t s_next;
	logic tick;
	logic take_byte;
	logic fin;
	logic [15:0] npc;
	logic [7:0] rel;

	// ============================================================
	// Opcode decode.
	function automatic cid_dec_t cid_decode(input logic [7:0] op);
		cid_dec_t d;
		logic [3:0] hi;
		logic [3:0] lo;
		cid_am_t am;
		d.cls = CID_OTHER;
		d.mode = CID_AM_NONE;
		d.len = `CID_LEN1;
		d.cyc = `CID_CYC1;
		d.fc = 1'b0;
		d.fov = 1'b0;
		d.fac = 1'b0;
		d.cclr = 1'b0;
		hi = op[7:4];
		lo = op[3:0];
		// Columns 4 to F share one operand layout across the arithmetic rows.
		if (op[3])
			am = CID_AM_REG;
		else if (lo == `CID_LO_DIR)
			am = CID_AM_DIR;
		else if (lo[3:1] == `CID_LO_IND)
			am = CID_AM_IND;
		else if (lo == `CID_LO_ACC)
			am = CID_AM_IMM;
		else
			am = CID_AM_NONE;
		if (am != CID_AM_NONE)
		begin
			d.mode = am;
			if ((am == CID_AM_DIR) || (am == CID_AM_IMM))
				d.len = `CID_LEN2;
			case (hi)
				`CID_HI_ADD: d.cls = CID_ADD;
				`CID_HI_ADD_WITH_CARRY: d.cls = CID_ADD_WITH_CARRY;
				`CID_HI_SUBTRACT_WITH_BORROW: d.cls = CID_SUBTRACT_WITH_BORROW;
				`CID_HI_INC: d.cls = CID_INC;
				`CID_HI_DEC: d.cls = CID_DEC;
				`CID_HI_COMPARE_BRANCH_UNEQUAL: d.cls = CID_COMPARE_BRANCH_UNEQUAL;
				`CID_HI_DECREMENT_BRANCH_NONZERO: d.cls = CID_DECREMENT_BRANCH_NONZERO;
				default: d.cls = CID_OTHER;
			endcase
			if ((d.cls == CID_ADD) || (d.cls == CID_ADD_WITH_CARRY) || (d.cls == CID_SUBTRACT_WITH_BORROW))
			begin
				d.fc = 1'b1;
				d.fov = 1'b1;
				d.fac = 1'b1;
			end
			else if ((d.cls == CID_INC) || (d.cls == CID_DEC))
			begin
				// Column 4 of these rows is the accumulator, not immediate data.
				if (am == CID_AM_IMM)
				begin
					d.mode = CID_AM_NONE;
					d.len = `CID_LEN1;
				end
			end
			else if (d.cls == CID_COMPARE_BRANCH_UNEQUAL)
			begin
				d.len = `CID_LEN3;
				d.cyc = `CID_CYC2;
				d.fc = 1'b1;
			end
			else if (d.cls == CID_DECREMENT_BRANCH_NONZERO)
			begin
				d.len = (am == CID_AM_DIR) ? `CID_LEN3 : `CID_LEN2;
				d.cyc = `CID_CYC2;
				if ((am != CID_AM_DIR) && (am != CID_AM_REG))
				begin
					d.cls = CID_OTHER;
					d.mode = CID_AM_NONE;
					d.len = `CID_LEN1;
					d.cyc = `CID_CYC1;
				end
			end
			else
			begin
				d.mode = CID_AM_NONE;
				d.len = `CID_LEN1;
			end
		end
		if (lo == `CID_LO_PAGE)
		begin
			d.cls = op[`CID_PAGE_LOW] ? CID_PCALL : CID_PJMP;
			d.len = `CID_LEN2;
			d.cyc = `CID_CYC2;
		end
		case (op)
			`CID_OP_NOP: d.cls = CID_NOP;
			`CID_OP_INC_DP:
			begin
				d.cls = CID_INC_DP;
				d.cyc = `CID_CYC2;
			end
			`CID_OP_MUL, `CID_OP_DIV:
			begin
				d.cls = (op == `CID_OP_MUL) ? CID_MUL : CID_DIV;
				d.cyc = `CID_CYC4;
				d.cclr = 1'b1;
				d.fov = 1'b1;
			end
			`CID_OP_DA:
			begin
				d.cls = CID_DA;
				d.fc = 1'b1;
			end
			`CID_OP_LAND, `CID_OP_LOR, `CID_OP_LXOR:
			begin
				d.cls = (op == `CID_OP_LAND) ? CID_LAND :
					(op == `CID_OP_LOR) ? CID_LOR : CID_LXOR;
				d.mode = CID_AM_DIR;
				d.len = `CID_LEN3;
				d.cyc = `CID_CYC2;
			end
			`CID_OP_CLR_A: d.cls = CID_CLR_A;
			`CID_OP_CPL_A: d.cls = CID_CPL_A;
			`CID_OP_RL: d.cls = CID_RL;
			`CID_OP_RR: d.cls = CID_RR;
			`CID_OP_SWAP: d.cls = CID_SWAP;
			`CID_OP_RLC, `CID_OP_RRC:
			begin
				d.cls = (op == `CID_OP_RLC) ? CID_RLC : CID_RRC;
				d.fc = 1'b1;
			end
			`CID_OP_CT_DP, `CID_OP_CT_PC:
			begin
				d.cls = (op == `CID_OP_CT_DP) ? CID_CT_DP : CID_CT_PC;
				d.cyc = `CID_CYC2;
			end
			`CID_OP_AUX_RD, `CID_OP_AUX_WR:
			begin
				d.cls = (op == `CID_OP_AUX_RD) ? CID_AUX_RD : CID_AUX_WR;
				d.cyc = `CID_CYC2;
			end
			`CID_OP_XCHD0, `CID_OP_XCHD1:
			begin
				d.cls = CID_LOW_NIBBLE_EXCHANGE;
				d.mode = CID_AM_IND;
			end
			`CID_OP_CLR_C, `CID_OP_SET_C, `CID_OP_CPL_C:
			begin
				d.cls = (op == `CID_OP_CLR_C) ? CID_CLR_C :
					(op == `CID_OP_SET_C) ? CID_SET_C : CID_CPL_C;
				d.fc = 1'b1;
			end
			`CID_OP_CLR_BIT, `CID_OP_SET_BIT, `CID_OP_CPL_BIT:
			begin
				d.cls = (op == `CID_OP_CLR_BIT) ? CID_CLR_BIT :
					(op == `CID_OP_SET_BIT) ? CID_SET_BIT : CID_CPL_BIT;
				d.mode = CID_AM_BIT;
				d.len = `CID_LEN2;
			end
			`CID_OP_JBC:
			begin
				d.cls = CID_JBC;
				d.mode = CID_AM_BIT;
				d.len = `CID_LEN3;
				d.cyc = `CID_CYC2;
			end
			`CID_OP_FCALL, `CID_OP_FJMP:
			begin
				d.cls = (op == `CID_OP_FCALL) ? CID_FCALL : CID_FJMP;
				d.len = `CID_LEN3;
				d.cyc = `CID_CYC2;
			end
			`CID_OP_RET, `CID_OP_INTERRUPT_RETURN:
			begin
				d.cls = (op == `CID_OP_RET) ? CID_RET : CID_INTERRUPT_RETURN;
				d.cyc = `CID_CYC2;
			end
			default: d.cls = d.cls;
		endcase
		return d;
	endfunction : cid_decode

	// ============================================================
	// Machine cycle timer.
	cid_mcycle u_mcycle
	(
		.clk(clk),
		.rstn(rstn),
		.run(s_reg.busy),
		.tick(tick)
	);

	assign take_byte = code_valid && s_reg.rdy;

	// ============================================================
	// Fetch and execution sequence.
	always_comb
	begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.tick = tick;
		fin = 1'b0;
		npc = 16'h0000;
		rel = 8'h00;
		case (s_reg.fsm)
			CID_ST_IDLE:
			begin
				if (take_byte)
				begin
					s_next.op = code_byte;
					s_next.dec = cid_decode(code_byte);
					s_next.pc = pc_in;
					s_next.b1 = 8'h00;
					s_next.b2 = 8'h00;
					s_next.left = s_next.dec.len - `CID_LEN1;
					if (s_next.dec.len == `CID_LEN1)
						fin = 1'b1;
					else
						s_next.fsm = CID_ST_OPND;
				end
			end
			CID_ST_OPND:
			begin
				if (take_byte)
				begin
					// The first operand byte always lands in b1, the second in b2.
					if (s_reg.left == (s_reg.dec.len - `CID_LEN1))
						s_next.b1 = code_byte;
					else
						s_next.b2 = code_byte;
					s_next.left = s_reg.left - 2'h1;
					if (s_reg.left == 2'h1)
						fin = 1'b1;
				end
			end
			CID_ST_EXEC:
			begin
				if (tick)
				begin
					s_next.mcl = s_reg.mcl - 3'h1;
					if (s_reg.mcl == `CID_CYC1)
					begin
						s_next.fsm = CID_ST_IDLE;
						s_next.busy = 1'b0;
						s_next.done = 1'b1;
					end
				end
			end
			default: s_next.fsm = CID_ST_IDLE;
		endcase
		if (fin)
		begin
			s_next.fsm = CID_ST_EXEC;
			s_next.busy = 1'b1;
			s_next.mcl = s_next.dec.cyc;
			s_next.rsel = s_next.op[`CID_REG_FLD];
			s_next.isel = s_next.op[`CID_IND_BIT];
			if ((s_next.dec.mode == CID_AM_DIR) || (s_next.dec.mode == CID_AM_BIT))
				s_next.dir = s_next.b1;
			else
				s_next.dir = 8'h00;
			s_next.sfr = (s_next.dec.mode == CID_AM_DIR) && s_next.dir[`CID_SFR_BIT];
			// A flag update from the ALU must not override a direct write to the status word.
			s_next.program_status_word = ((s_next.dec.mode == CID_AM_DIR) && (s_next.dir == `CID_PSW_BYTE)) ||
				((s_next.dec.mode == CID_AM_BIT) && (s_next.dir >= `CID_PSW_BLO) &&
				(s_next.dir <= `CID_PSW_BHI));
			if ((s_next.dec.cls == CID_LAND) || (s_next.dec.cls == CID_LOR) ||
				(s_next.dec.cls == CID_LXOR))
				s_next.imm = s_next.b2;
			else
				s_next.imm = s_next.b1;
			npc = s_next.pc + {14'h0000, s_next.dec.len};
			rel = (s_next.dec.len == `CID_LEN3) ? s_next.b2 : s_next.b1;
			s_next.take = 1'b0;
			s_next.bclr = 1'b0;
			case (s_next.dec.cls)
				CID_PJMP, CID_PCALL:
				begin
					s_next.tgt = {npc[`CID_PAGE_PC], s_next.op[`CID_PAGE_OP], s_next.b1};
					s_next.take = 1'b1;
				end
				CID_FJMP, CID_FCALL:
				begin
					s_next.tgt = {s_next.b1, s_next.b2};
					s_next.take = 1'b1;
				end
				CID_JBC, CID_COMPARE_BRANCH_UNEQUAL, CID_DECREMENT_BRANCH_NONZERO:
				begin
					s_next.tgt = npc + {{8{rel[7]}}, rel};
					if (s_next.dec.cls == CID_JBC)
					begin
						s_next.take = bit_val;
						s_next.bclr = bit_val;
					end
				end
				default: s_next.tgt = npc;
			endcase
		end
		s_next.rdy = (s_next.fsm != CID_ST_EXEC);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// ============================================================
	// Outputs, all straight from the state register.
	assign code_ready = s_reg.rdy;
	assign busy = s_reg.busy;
	assign instr_done = s_reg.done;
	assign mc_tick = s_reg.tick;
	assign op_class = s_reg.dec.cls;
	assign addr_mode = s_reg.dec.mode;
	assign instr_len = s_reg.dec.len;
	assign exec_cycles = s_reg.dec.cyc;
	assign carry_upd = s_reg.dec.fc;
	assign overflow_flag_upd = s_reg.dec.fov;
	assign aux_carry_flag_upd = s_reg.dec.fac;
	assign carry_clr = s_reg.dec.cclr;
	assign reg_sel = s_reg.rsel;
	assign ind_sel = s_reg.isel;
	assign dir_addr = s_reg.dir;
	assign dir_is_sfr = s_reg.sfr;
	assign status_word_touch = s_reg.program_status_word;
	assign imm_data = s_reg.imm;
	assign branch_target = s_reg.tgt;
	assign branch_take = s_reg.take;
	assign bit_clear = s_reg.bclr;

endmodule : cid_decoder

// ---- bench/cid_decoder_asserts.sv ----
// Concurrent checks on the ports of the instruction decoder.
`timescale 1ns/100ps
module cid_decoder_asserts
	import cid_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic code_ready,
	input wire logic busy,
	input wire logic instr_done,
	input wire logic mc_tick,
	input wire cid_pkg::cid_op_t op_class,
	input wire cid_pkg::cid_am_t addr_mode,
	input wire logic [2:0] exec_cycles,
	input wire logic carry_upd,
	input wire logic overflow_flag_upd,
	input wire logic aux_carry_flag_upd,
	input wire logic carry_clr,
	input wire logic [7:0] dir_addr,
	input wire logic dir_is_sfr,
	input wire logic status_word_touch,
	input wire logic branch_take,
	input wire logic bit_clear
);
	// ============================================================
	// Helper logic and sequences.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic [6:0] busy_cnt_reg;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			busy_cnt_reg <= 7'h00;
		else if (busy)
			busy_cnt_reg <= busy_cnt_reg + 7'h01;
		else
			busy_cnt_reg <= 7'h00;
	sequence s_start;
		$rose(busy);
	endsequence
	sequence s_muldiv;
		$rose(busy) && (op_class == CID_MUL || op_class == CID_DIV);
	endsequence
	sequence s_arith;
		$rose(busy) && (op_class == CID_ADD || op_class == CID_ADD_WITH_CARRY || op_class == CID_SUBTRACT_WITH_BORROW);
	endsequence
	// ============================================================
	// Assertions.
	a_busy_span: assert property ($fell(busy) |-> busy_cnt_reg == 7'h0c * exec_cycles)
		else $error("busy span differs from machine cycle count");
	a_tick_first: assert property (s_start |-> (!mc_tick) [*8] ##5 mc_tick)
		else $error("first machine tick not twelve clocks after start");
	a_tick_inside: assert property (mc_tick |-> $past(busy))
		else $error("machine tick outside execution");
	a_done_end: assert property (instr_done |-> $fell(busy) && code_ready)
		else $error("done pulse not at end of execution");
	a_no_take_busy: assert property (busy |-> !code_ready)
		else $error("byte port ready while executing");
	a_muldiv_flags: assert property (s_muldiv |-> exec_cycles == 3'h4 && carry_clr && overflow_flag_upd)
		else $error("multiply or divide cycles or flags wrong");
	a_arith_flags: assert property (s_arith |-> carry_upd && overflow_flag_upd && aux_carry_flag_upd)
		else $error("arithmetic flag updates missing");
	a_sfr_split: assert property (s_start ##0 addr_mode == CID_AM_DIR |-> dir_is_sfr == dir_addr[7])
		else $error("direct space split wrong");
	a_status_touch: assert property (s_start |-> status_word_touch == ((addr_mode == CID_AM_DIR && dir_addr == 8'hd0) || (addr_mode == CID_AM_BIT && dir_addr inside {[8'hd1:8'hd7]})))
		else $error("status word touch flag wrong");
	a_bit_clear: assert property (bit_clear |-> branch_take && op_class == CID_JBC)
		else $error("bit clear without taken bit branch");
endmodule : cid_decoder_asserts

// ---- bench/cid_code_mem.sv ----
// Program memory model that hands instruction bytes to the decoder.
`timescale 1ns/100ps
module cid_code_mem
(
	input wire logic clk,
	input wire logic code_ready,
	output logic code_valid,
	output logic [7:0] code_byte
);
	// ============================================================
	// Byte delivery.
	initial
	begin
		code_valid = 1'h0;
		code_byte = 8'h00;
	end
	// Bytes are sent from the top of the vector; gap idles the port before each byte.
	// A released byte line shows the inverse of the last byte, so stale data cannot pass.
	task feed(input logic [23:0] b, input int n, input int gap);
		int i;
		for (i = 0; i < n; i++)
		begin
			if (gap > 0)
			begin
				code_valid <= 1'h0;
				repeat (gap) @(posedge clk);
			end
			code_valid <= 1'h1;
			code_byte <= b[23 - 8 * i -: 8];
			do
				@(posedge clk);
			while (code_ready !== 1'b1);
			if (i == n - 1 || gap > 0)
				code_byte <= ~b[23 - 8 * i -: 8];
		end
		code_valid <= 1'h0;
	endtask : feed
endmodule : cid_code_mem

// ---- bench/tb_cpu_instruction_decoder.sv ----
// Self-checking testbench for the instruction decoder.
`timescale 1ns/100ps
module tb_cpu_instruction_decoder;
	import cid_pkg::*;
	logic clk, rstn, code_valid, bit_val, code_ready, busy, instr_done, mc_tick;
	logic carry_upd, overflow_flag_upd, aux_carry_flag_upd, carry_clr, ind_sel, dir_is_sfr;
	logic status_word_touch, branch_take, bit_clear;
	logic [7:0] code_byte, dir_addr, imm_data;
	logic [15:0] pc_in, branch_target;
	logic [2:0] exec_cycles, reg_sel;
	logic [1:0] instr_len;
	cid_op_t op_class;
	cid_am_t addr_mode;
	int fail_count, cmp_count;
	// Opcode, expected class, then length and cycle nibbles.
	logic [21:0] tv_q [$] = '{{8'h2b,CID_ADD,8'h11}, {8'h25,CID_ADD,8'h21}, {8'h27,CID_ADD,8'h11},
		{8'h24,CID_ADD,8'h21}, {8'h3f,CID_ADD_WITH_CARRY,8'h11}, {8'h35,CID_ADD_WITH_CARRY,8'h21}, {8'h36,CID_ADD_WITH_CARRY,8'h11},
		{8'h34,CID_ADD_WITH_CARRY,8'h21}, {8'h9a,CID_SUBTRACT_WITH_BORROW,8'h11}, {8'h95,CID_SUBTRACT_WITH_BORROW,8'h21}, {8'h97,CID_SUBTRACT_WITH_BORROW,8'h11},
		{8'h94,CID_SUBTRACT_WITH_BORROW,8'h21}, {8'h04,CID_INC,8'h11}, {8'h0d,CID_INC,8'h11}, {8'h05,CID_INC,8'h21},
		{8'h14,CID_DEC,8'h11}, {8'h1e,CID_DEC,8'h11}, {8'h15,CID_DEC,8'h21}, {8'ha3,CID_INC_DP,8'h12},
		{8'ha4,CID_MUL,8'h14}, {8'h84,CID_DIV,8'h14}, {8'hd4,CID_DA,8'h11}, {8'h53,CID_LAND,8'h32},
		{8'h43,CID_LOR,8'h32}, {8'h63,CID_LXOR,8'h32}, {8'he4,CID_CLR_A,8'h11}, {8'hf4,CID_CPL_A,8'h11},
		{8'h23,CID_RL,8'h11}, {8'h33,CID_RLC,8'h11}, {8'h03,CID_RR,8'h11}, {8'h13,CID_RRC,8'h11},
		{8'hc4,CID_SWAP,8'h11}, {8'h93,CID_CT_DP,8'h12}, {8'h83,CID_CT_PC,8'h12}, {8'he0,CID_AUX_RD,8'h12},
		{8'hf0,CID_AUX_WR,8'h12}, {8'hd7,CID_LOW_NIBBLE_EXCHANGE,8'h11}, {8'hc3,CID_CLR_C,8'h11}, {8'hd3,CID_SET_C,8'h11},
		{8'hb3,CID_CPL_C,8'h11}, {8'hc2,CID_CLR_BIT,8'h21}, {8'hd2,CID_SET_BIT,8'h21},
		{8'hb2,CID_CPL_BIT,8'h21}, {8'h12,CID_FCALL,8'h32}, {8'h02,CID_FJMP,8'h32}, {8'hb4,CID_COMPARE_BRANCH_UNEQUAL,8'h32},
		{8'hb5,CID_COMPARE_BRANCH_UNEQUAL,8'h32}, {8'hb6,CID_COMPARE_BRANCH_UNEQUAL,8'h32}, {8'hb9,CID_COMPARE_BRANCH_UNEQUAL,8'h32}, {8'hd5,CID_DECREMENT_BRANCH_NONZERO,8'h32},
		{8'hdc,CID_DECREMENT_BRANCH_NONZERO,8'h22}, {8'h22,CID_RET,8'h12}, {8'h32,CID_INTERRUPT_RETURN,8'h12}, {8'h00,CID_NOP,8'h11}};
	// Opcode, direct operand, expected space flag and status word touch.
	logic [17:0] dq [$] = '{{8'h25,8'h7f,2'b00}, {8'h25,8'h80,2'b10}, {8'h25,8'hd0,2'b11},
		{8'hc2,8'hd1,2'b01}, {8'hb2,8'hd7,2'b01}, {8'hd2,8'hd8,2'b00}, {8'hc2,8'hd0,2'b00}};
	cid_decoder uut (.clk, .rstn, .code_valid, .code_byte, .pc_in, .bit_val, .code_ready, .busy,
		.instr_done, .mc_tick, .op_class, .addr_mode, .instr_len, .exec_cycles, .carry_upd,
		.overflow_flag_upd, .aux_carry_flag_upd, .carry_clr, .reg_sel, .ind_sel, .dir_addr, .dir_is_sfr,
		.status_word_touch, .imm_data, .branch_target, .branch_take, .bit_clear);
	cid_code_mem mem (.clk, .code_ready, .code_valid, .code_byte);
	// ============================================================
	// Shared tasks.
	task check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	// Sends one instruction and waits, bounded, for its done pulse.
	task run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2, input int n,
		input int gap);
		int k;
		mem.feed({op, b1, b2}, n, gap);
		k = 0;
		while (instr_done !== 1'b1 && k < 200)
		begin
			@(posedge clk);
			k++;
		end
		check({15'h0, instr_done}, 16'h1);
	endtask : run
	// ============================================================
	// Scenarios.
	task t_table;
		for (int i = 0; i < tv_q.size(); i++)
		begin
			run(tv_q[i][21:14], 8'h00, 8'h00, int'(tv_q[i][7:4]), i % 3);
			check(op_class, tv_q[i][13:8]);
			check({2'h0, instr_len, 1'h0, exec_cycles}, tv_q[i][7:0]);
			if (addr_mode === CID_AM_REG)
				check(reg_sel, tv_q[i][16:14]);
			if (addr_mode === CID_AM_IND)
				check(ind_sel, tv_q[i][14]);
		end
	endtask : t_table
	task t_branch;
		pc_in <= 16'h3ffe;
		run(8'h71, 8'h5a, 8'h00, 2, 0);
		check({branch_take, branch_target}, 17'h1435a);
		pc_in <= 16'hf7fe;
		run(8'he1, 8'h01, 8'h00, 2, 1);
		check({branch_take, branch_target}, 17'h1ff01);
		pc_in <= 16'h0100;
		bit_val <= 1'h1;
		run(8'h10, 8'hd3, 8'h80, 3, 0);
		check({bit_clear, branch_take, branch_target}, 18'h30083);
		bit_val <= 1'h0;
		run(8'h10, 8'h20, 8'h80, 3, 2);
		check({bit_clear, branch_take, 2'h0, instr_len}, 4'h3);
		pc_in <= 16'h0200;
		run(8'hb4, 8'h11, 8'h7f, 3, 2);
		check(branch_target, 16'h0282);
		pc_in <= 16'h7ff0;
		run(8'h12, 8'hab, 8'hcd, 3, 3);
		check({branch_take, branch_target}, 17'h1abcd);
	endtask : t_branch
	task t_operand;
		for (int i = 0; i < dq.size(); i++)
		begin
			run(dq[i][17:10], dq[i][9:2], 8'h00, 2, 0);
			check({dir_is_sfr, status_word_touch}, dq[i][1:0]);
		end
		run(8'h53, 8'h30, 8'hc5, 3, 1);
		check({dir_addr, imm_data}, 16'h30c5);
		run(8'ha4, 8'h00, 8'h00, 1, 0);
		check({carry_clr, overflow_flag_upd}, 2'h3);
		run(8'h33, 8'h00, 8'h00, 1, 0);
		check(carry_upd, 1'h1);
		run(8'h94, 8'h00, 8'h00, 2, 0);
		check({carry_upd, overflow_flag_upd, aux_carry_flag_upd}, 3'h7);
	endtask : t_operand
	// ============================================================
	// Clock, watchdog and main sequence.
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		repeat (30000) @(posedge clk);
		fail_count++;
		complete_run;
	end
	initial
	begin
		rstn = 1'h0;
		bit_val = 1'h0;
		pc_in = 16'h0000;
		fail_count = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		check({busy, code_ready, op_class}, 8'h00);
		rstn <= 1'h1;
		repeat (2) @(posedge clk);
		check(code_ready, 1'h1);
		t_table;
		t_branch;
		t_operand;
		complete_run;
	end
endmodule : tb_cpu_instruction_decoder
bind cid_decoder cid_decoder_asserts chk (.clk, .rstn, .code_ready, .busy, .instr_done, .mc_tick,
	.op_class, .addr_mode, .exec_cycles, .carry_upd, .overflow_flag_upd, .aux_carry_flag_upd,
	.carry_clr, .dir_addr, .dir_is_sfr, .status_word_touch, .branch_take, .bit_clear);
